// *** core/board_ctrl_pkg.sv ***
/*
  Shared constants and types for the board control register bank.
  Assumes a single 100 MHz clock domain and a synchronous active-high reset.
*/
// Contract
// - First bit of each slot is delayed by the 9-bit offset after frame sync.
// - Offset counts data bit periods before transmission starts on the transmit line.
// - Every later bit and slot keeps the same offset, not only the first.
// - Offset field resets to 1a3.
// - Offset register bits 15 to 9 are unused and read as zero.
// - Word at 1ff8 holds 10-bit alpha coefficient, reset value a4.
// - Word at 1ff6 holds 8-bit beta coefficient, reset value zero.
// - Writing all ones to 7fff clears the command interface address and data words.
// - The internal program ROM is neither readable nor writable from the host.
// - Each board word drives one setting shared by all sixteen channels.
package board_ctrl_pkg;

  // Serial command frame layout
  localparam int          WORD_W      = 16;
  localparam int          ADDR_W      = 15;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  WORD_BITS   = 5'h10;
  localparam int          RD_FLAG_BIT = 15;

  // Register addresses
  localparam logic [14:0] ADDR_BETA    = 15'h1ff6;
  localparam logic [14:0] ADDR_ALPHA   = 15'h1ff8;
  localparam logic [14:0] ADDR_TZ      = 15'h1ffa;
  localparam logic [14:0] ADDR_OFFSET  = 15'h1ffc;
  localparam logic [14:0] ADDR_CMD_CLR = 15'h7fff;
  localparam logic [15:0] CLEAR_KEY    = 16'hffff;

  // Field widths
  localparam int OFFSET_W = 9;
  localparam int TZ_W     = 5;
  localparam int ALPHA_W  = 10;
  localparam int BETA_W   = 8;

  // Reset values
  localparam logic [8:0] OFFSET_RST = 9'h1a3;
  localparam logic [4:0] TZ_RST     = 5'h00;
  localparam logic [9:0] ALPHA_RST  = 10'h0a4;
  localparam logic [7:0] BETA_RST   = 8'h00;

  // Transmit timing: bit position width in frame and slot-start value of the low position bits
  localparam int         POS_W     = 9;
  localparam logic [2:0] SLOT_ZERO = 3'h0;

  // Pin synchroniser width: sclk, cs_n, din, bit clock, frame sync
  localparam int SYNC_W = 5;
  localparam int S_UPCK = 0;
  localparam int S_CS_N = 1;
  localparam int S_DIN  = 2;
  localparam int S_SCK  = 3;
  localparam int S_FS   = 4;
  // Idle pin levels: clocks and data low, chip select high
  localparam logic [4:0] SYNC_IDLE = 5'h02;

  typedef enum logic [1:0] {SP_IDLE, SP_ADDR, SP_DATA} port_state_t;

endpackage

// *** core/slot_timing_if.sv ***
/*
  Carrier between the register bank and the transmit slot timer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface slot_timing_if;
  logic [8:0] bit_offset;
  logic       sck_rise;
  logic       frame_start;
  logic [8:0] tx_bit_pos;
  logic       tx_slot_start;
  logic       tx_active;

  modport ctrl  (output bit_offset, sck_rise, frame_start,
                 input  tx_bit_pos, tx_slot_start, tx_active);
  modport timer (input  bit_offset, sck_rise, frame_start,
                 output tx_bit_pos, tx_slot_start, tx_active);
endinterface

// *** core/slot_timer.sv ***
/*
  Transmit slot timer: frame position counter that shifts the transmit bit
  position by the programmed slot bit offset.
  Assumes one-cycle pulses for bit clock rise and frame start, same clock.
*/
`timescale 1ns/100ps
module slot_timer (
  input wire logic       clk_i,
  input wire logic       rst_i,
  slot_timing_if.timer   tif
);

  logic [8:0] pos_ff;
  logic [8:0] nxt_pos;
  logic       pend_ff;
  logic       nxt_pend;
  logic [8:0] bitpos_ff;
  logic [8:0] nxt_bitpos;
  logic       start_ff;
  logic       nxt_start;
  logic       active_ff;
  logic       nxt_active;

  // Position restarts at the bit clock following frame sync
  always_comb begin
    nxt_pos    = pos_ff;
    nxt_pend   = pend_ff | tif.frame_start;
    nxt_bitpos = bitpos_ff;
    nxt_start  = 1'b0;
    nxt_active = active_ff;
    if (tif.sck_rise) begin
      nxt_pos    = pend_ff ? '0 : 9'(pos_ff + 9'h001);
      nxt_pend   = tif.frame_start;
      // Shifted position wraps, so all later slots keep the offset
      nxt_bitpos = 9'(nxt_pos - tif.bit_offset);
      if (nxt_pos == tif.bit_offset) begin
        nxt_active = 1'b1;
      end
      nxt_start = (nxt_active || nxt_pos == tif.bit_offset) &&
                  (nxt_bitpos[2:0] == board_ctrl_pkg::SLOT_ZERO);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_ff    <= '0;
      pend_ff   <= 1'b0;
      bitpos_ff <= '0;
      start_ff  <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      pos_ff    <= nxt_pos;
      pend_ff   <= nxt_pend;
      bitpos_ff <= nxt_bitpos;
      start_ff  <= nxt_start;
      active_ff <= nxt_active;
    end
  end

  assign tif.tx_bit_pos    = bitpos_ff;
  assign tif.tx_slot_start = start_ff;
  assign tif.tx_active     = active_ff;

endmodule

// *** core/board_control_registers.sv ***
/*
  Board control register bank: serial host port, the shared board words,
  the command interface clear, and the transmit slot offset timing.
  Assumes host serial pins and PCM pins are asynchronous to CLK_I and slow
  enough that each edge is seen after the two-flop synchroniser.
*/
`timescale 1ns/100ps
module board_control_registers (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Serial host port
  input  wire logic        UPCK_I,
  input  wire logic        UPCS_N_I,
  input  wire logic        UPDI_I,
  output logic             UPDO_O,
  output logic             UPDO_OE_N_O,
  // PCM timing inputs
  input  wire logic        SCK_I,
  input  wire logic        FRAME_SYNC_STROBE_I,
  // Transmit slot timing
  output logic [8:0]       TX_BIT_POS_O,
  output logic             TX_SLOT_START_O,
  output logic             TX_ACTIVE_O,
  // Shared board settings
  output logic [8:0]       SLOT_BIT_OFFSET_O,
  output logic [4:0]       TERMINATION_IMPEDANCE_TEST_O,
  output logic [9:0]       ALPHA_COEFF_O,
  output logic [7:0]       BETA_COEFF_O,
  // Command interface words
  output logic [14:0]      CMD_ADDR_WORD_O,
  output logic [15:0]      CMD_DATA_WORD_O
);

  slot_timing_if tif ();

  // Read decode; ROM space and unused bits return zero
  function automatic logic [15:0] reg_read(
    input logic [14:0] addr,
    input logic [8:0]  offs,
    input logic [4:0]  tz,
    input logic [9:0]  alpha,
    input logic [7:0]  beta
  );
    logic [15:0] val;
    val = 16'h0000;
    unique case (addr)
      board_ctrl_pkg::ADDR_OFFSET: val = {7'h00, offs};
      board_ctrl_pkg::ADDR_TZ:     val = {11'h000, tz};
      board_ctrl_pkg::ADDR_ALPHA:  val = {6'h00, alpha};
      board_ctrl_pkg::ADDR_BETA:   val = {8'h00, beta};
      default:                     val = 16'h0000;
    endcase
    return val;
  endfunction

  // Pin synchroniser; stage one is only read by stage two
  logic [board_ctrl_pkg::SYNC_W-1:0] meta_ff;
  logic [board_ctrl_pkg::SYNC_W-1:0] sync_ff;
  logic [board_ctrl_pkg::SYNC_W-1:0] prev_ff;
  logic [board_ctrl_pkg::SYNC_W-1:0] nxt_meta;
  logic [board_ctrl_pkg::SYNC_W-1:0] nxt_sync;
  logic [board_ctrl_pkg::SYNC_W-1:0] nxt_prev;

  always_comb begin
    nxt_meta = {FRAME_SYNC_STROBE_I, SCK_I, UPDI_I, UPCS_N_I, UPCK_I};
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  // Idle levels: clocks low, chip select high
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      meta_ff <= board_ctrl_pkg::SYNC_IDLE;
      sync_ff <= board_ctrl_pkg::SYNC_IDLE;
      prev_ff <= board_ctrl_pkg::SYNC_IDLE;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  logic upck_rise;
  logic upck_fall;
  logic cs_active;
  logic din;

  // Edge strobes taken from the synchronised copies
  assign upck_rise = sync_ff[board_ctrl_pkg::S_UPCK] & ~prev_ff[board_ctrl_pkg::S_UPCK];
  assign upck_fall = ~sync_ff[board_ctrl_pkg::S_UPCK] & prev_ff[board_ctrl_pkg::S_UPCK];
  assign cs_active = ~sync_ff[board_ctrl_pkg::S_CS_N];
  assign din       = sync_ff[board_ctrl_pkg::S_DIN];

  // Serial port and register state
  board_ctrl_pkg::port_state_t state_ff;
  board_ctrl_pkg::port_state_t nxt_state;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic        rd_ff;
  logic        nxt_rd;
  logic [14:0] addr_word_ff;
  logic [14:0] nxt_addr_word;
  logic [15:0] data_word_ff;
  logic [15:0] nxt_data_word;
  logic        dout_ff;
  logic        nxt_dout;
  logic        oe_n_ff;
  logic        nxt_oe_n;
  logic [8:0]  offs_ff;
  logic [8:0]  nxt_offs;
  logic [4:0]  tz_ff;
  logic [4:0]  nxt_tz;
  logic [9:0]  alpha_ff;
  logic [9:0]  nxt_alpha;
  logic [7:0]  beta_ff;
  logic [7:0]  nxt_beta;
  logic [15:0] wr_word;

  assign wr_word = {shift_ff[14:0], din};

  // Frame: 16 address bits (read flag first), then 16 data bits, MSB first
  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_shift     = shift_ff;
    nxt_rd        = rd_ff;
    nxt_addr_word = addr_word_ff;
    nxt_data_word = data_word_ff;
    nxt_dout      = dout_ff;
    nxt_oe_n      = oe_n_ff;
    nxt_offs      = offs_ff;
    nxt_tz        = tz_ff;
    nxt_alpha     = alpha_ff;
    nxt_beta      = beta_ff;
    if (!cs_active) begin
      // Deselect aborts a partial frame and releases the data pin
      nxt_state = board_ctrl_pkg::SP_IDLE;
      nxt_oe_n  = 1'b1;
    end else begin
      unique case (state_ff)
        board_ctrl_pkg::SP_IDLE: begin
          nxt_state = board_ctrl_pkg::SP_ADDR;
          nxt_cnt   = '0;
        end
        board_ctrl_pkg::SP_ADDR: begin
          if (upck_rise) begin
            nxt_shift = wr_word;
            nxt_cnt   = 5'(cnt_ff + 5'h01);
            if (nxt_cnt == board_ctrl_pkg::WORD_BITS) begin
              nxt_state     = board_ctrl_pkg::SP_DATA;
              nxt_cnt       = '0;
              nxt_rd        = wr_word[board_ctrl_pkg::RD_FLAG_BIT];
              nxt_addr_word = wr_word[board_ctrl_pkg::ADDR_W-1:0];
              if (nxt_rd) begin
                // Load read data; first bit goes out on the next fall
                nxt_shift = reg_read(nxt_addr_word, offs_ff, tz_ff,
                                     alpha_ff, beta_ff);
              end
            end
          end
        end
        board_ctrl_pkg::SP_DATA: begin
          if (rd_ff) begin
            if (upck_fall) begin
              nxt_dout  = shift_ff[board_ctrl_pkg::WORD_W-1];
              nxt_oe_n  = 1'b0;
              nxt_shift = {shift_ff[14:0], 1'b0};
              nxt_cnt   = 5'(cnt_ff + 5'h01);
              if (nxt_cnt == board_ctrl_pkg::WORD_BITS) begin
                nxt_state = board_ctrl_pkg::SP_ADDR;
                nxt_cnt   = '0;
              end
            end
          end else if (upck_rise) begin
            nxt_shift = wr_word;
            nxt_cnt   = 5'(cnt_ff + 5'h01);
            if (nxt_cnt == board_ctrl_pkg::WORD_BITS) begin
              nxt_state     = board_ctrl_pkg::SP_ADDR;
              nxt_cnt       = '0;
              nxt_data_word = wr_word;
              // Only the documented fields are stored; other bits drop
              unique case (addr_word_ff)
                board_ctrl_pkg::ADDR_OFFSET:
                  nxt_offs = wr_word[board_ctrl_pkg::OFFSET_W-1:0];
                board_ctrl_pkg::ADDR_TZ:
                  nxt_tz = wr_word[board_ctrl_pkg::TZ_W-1:0];
                board_ctrl_pkg::ADDR_ALPHA:
                  nxt_alpha = wr_word[board_ctrl_pkg::ALPHA_W-1:0];
                board_ctrl_pkg::ADDR_BETA:
                  nxt_beta = wr_word[board_ctrl_pkg::BETA_W-1:0];
                board_ctrl_pkg::ADDR_CMD_CLR: begin
                  if (wr_word == board_ctrl_pkg::CLEAR_KEY) begin
                    nxt_addr_word = '0;
                    nxt_data_word = '0;
                  end
                end
                default: ; // ROM and unmapped space ignore writes
              endcase
            end
          end
        end
        default: nxt_state = board_ctrl_pkg::SP_IDLE;
      endcase
    end
  end

  // Register the serial port and the board words
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_ff     <= board_ctrl_pkg::SP_IDLE;
      cnt_ff       <= '0;
      shift_ff     <= '0;
      rd_ff        <= 1'b0;
      addr_word_ff <= '0;
      data_word_ff <= '0;
      dout_ff      <= 1'b0;
      oe_n_ff      <= 1'b1;
      offs_ff      <= board_ctrl_pkg::OFFSET_RST;
      tz_ff        <= board_ctrl_pkg::TZ_RST;
      alpha_ff     <= board_ctrl_pkg::ALPHA_RST;
      beta_ff      <= board_ctrl_pkg::BETA_RST;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      shift_ff     <= nxt_shift;
      rd_ff        <= nxt_rd;
      addr_word_ff <= nxt_addr_word;
      data_word_ff <= nxt_data_word;
      dout_ff      <= nxt_dout;
      oe_n_ff      <= nxt_oe_n;
      offs_ff      <= nxt_offs;
      tz_ff        <= nxt_tz;
      alpha_ff     <= nxt_alpha;
      beta_ff      <= nxt_beta;
    end
  end

  // Bit clock and frame sync strobes for the slot timer
  assign tif.bit_offset  = offs_ff;
  assign tif.sck_rise    = sync_ff[board_ctrl_pkg::S_SCK] & ~prev_ff[board_ctrl_pkg::S_SCK];
  assign tif.frame_start = sync_ff[board_ctrl_pkg::S_FS] & ~prev_ff[board_ctrl_pkg::S_FS];

  slot_timer u_slot_timer (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .tif   (tif.timer)
  );

  // One set of board words serves every channel
  assign UPDO_O                       = dout_ff;
  assign UPDO_OE_N_O                  = oe_n_ff;
  assign TX_BIT_POS_O                 = tif.tx_bit_pos;
  assign TX_SLOT_START_O              = tif.tx_slot_start;
  assign TX_ACTIVE_O                  = tif.tx_active;
  assign SLOT_BIT_OFFSET_O            = offs_ff;
  assign TERMINATION_IMPEDANCE_TEST_O = tz_ff;
  assign ALPHA_COEFF_O                = alpha_ff;
  assign BETA_COEFF_O                 = beta_ff;
  assign CMD_ADDR_WORD_O              = addr_word_ff;
  assign CMD_DATA_WORD_O              = data_word_ff;

endmodule

// *** tb/board_ctrl_sva.sv ***
/*
  Checker for the board control register bank, bound to its top ports.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/100ps
module board_ctrl_sva (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // Serial host port
  input wire logic        UPCS_N_I,
  input wire logic        UPDO_OE_N_O,
  // Transmit timing
  input wire logic        SCK_I,
  input wire logic [8:0]  TX_BIT_POS_O,
  input wire logic        TX_SLOT_START_O,
  input wire logic        TX_ACTIVE_O,
  // Board settings and command words
  input wire logic [8:0]  SLOT_BIT_OFFSET_O,
  input wire logic [4:0]  TERMINATION_IMPEDANCE_TEST_O,
  input wire logic [9:0]  ALPHA_COEFF_O,
  input wire logic [7:0]  BETA_COEFF_O,
  input wire logic [14:0] CMD_ADDR_WORD_O,
  input wire logic [15:0] CMD_DATA_WORD_O
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  // Reset leaves the documented defaults in place
  chk_rst_words: assert property ($fell(RST_I) |-> SLOT_BIT_OFFSET_O == 9'h1a3
    && ALPHA_COEFF_O == 10'h0a4 && BETA_COEFF_O == 8'h00 && TERMINATION_IMPEDANCE_TEST_O == 5'h00)
    else $error("board words not at reset values");
  chk_rst_outputs: assert property ($fell(RST_I) |-> UPDO_OE_N_O && !TX_ACTIVE_O
    && CMD_ADDR_WORD_O == 15'h0000 && CMD_DATA_WORD_O == 16'h0000)
    else $error("port outputs not idle after reset");
  // Slot timing: pulse width, alignment and stickiness
  chk_slot_pulse: assert property (TX_SLOT_START_O |=> !TX_SLOT_START_O)
    else $error("slot start wider than one cycle");
  chk_active_hold: assert property (TX_ACTIVE_O |=> TX_ACTIVE_O)
    else $error("transmit active dropped without reset");
  chk_slot_align: assert property (TX_SLOT_START_O |-> TX_ACTIVE_O
    && TX_BIT_POS_O[2:0] == 3'h0)
    else $error("slot start off a slot boundary");
  chk_active_start: assert property ($rose(TX_ACTIVE_O) |-> TX_BIT_POS_O == 9'h000
    && TX_SLOT_START_O)
    else $error("transmission began away from the offset");
  // Position only moves on a bit clock rise
  chk_pos_hold: assert property ((!SCK_I)[*8] |-> $stable(TX_BIT_POS_O))
    else $error("bit position moved without a bit clock");
  // Board and command words hold and read data stays released while the host is deselected
  chk_cfg_idle: assert property (UPCS_N_I[*6] |-> $stable(SLOT_BIT_OFFSET_O)
    && $stable(ALPHA_COEFF_O) && $stable(BETA_COEFF_O) && $stable(TERMINATION_IMPEDANCE_TEST_O))
    else $error("board word changed while deselected");
  chk_cmd_idle: assert property (UPCS_N_I[*6] |-> $stable(CMD_ADDR_WORD_O)
    && $stable(CMD_DATA_WORD_O))
    else $error("command words changed while deselected");
  chk_oe_idle: assert property (UPCS_N_I[*5] |-> UPDO_OE_N_O)
    else $error("read data driven while deselected");

  // Main scenarios reached
  cov_slot: cover property (TX_SLOT_START_O);
  cov_read: cover property (!UPDO_OE_N_O);
  cov_active: cover property ($rose(TX_ACTIVE_O));
endmodule

// *** tb/board_control_registers_tb.sv ***
/*
  Self-checking bench for the board control register bank.
  Assumes the block's serial frame format and its synchronised slot timing.
*/
`timescale 1ns/100ps
module board_control_registers_tb;
  // Design pins
  logic        CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        UPCK_I = 1'b0;
  logic        UPCS_N_I = 1'b1;
  logic        UPDI_I = 1'b0;
  logic        SCK_I = 1'b0;
  logic        FRAME_SYNC_STROBE_I = 1'b0;
  logic        UPDO_O, UPDO_OE_N_O, TX_SLOT_START_O, TX_ACTIVE_O;
  logic [8:0]  TX_BIT_POS_O, SLOT_BIT_OFFSET_O;
  logic [4:0]  TERMINATION_IMPEDANCE_TEST_O;
  logic [9:0]  ALPHA_COEFF_O;
  logic [7:0]  BETA_COEFF_O;
  logic [14:0] CMD_ADDR_WORD_O;
  logic [15:0] CMD_DATA_WORD_O;
  // Bench state and register model
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_slot = 0;
  int          exp_slot = 0;
  logic [31:0] seed = 32'h00014b80;
  logic [15:0] q;
  int          model[logic [14:0]];
  int          msk[logic [14:0]];
  logic [14:0] addrs[7] = '{15'h1ff6, 15'h1ff8, 15'h1ffa, 15'h1ffc, 15'h7fff, 15'h0400, 15'h1ffe};

  always #5 CLK_I = ~CLK_I;

  // Count slot pulses as they happen, since each stands one cycle
  always @(posedge CLK_I)
    if (TX_SLOT_START_O === 1'b1)
      n_slot <= n_slot + 1;

  board_control_registers u_dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .UPCK_I(UPCK_I), .UPCS_N_I(UPCS_N_I), .UPDI_I(UPDI_I),
    .UPDO_O(UPDO_O), .UPDO_OE_N_O(UPDO_OE_N_O), .SCK_I(SCK_I),
    .FRAME_SYNC_STROBE_I(FRAME_SYNC_STROBE_I), .TX_BIT_POS_O(TX_BIT_POS_O),
    .TX_SLOT_START_O(TX_SLOT_START_O), .TX_ACTIVE_O(TX_ACTIVE_O),
    .SLOT_BIT_OFFSET_O(SLOT_BIT_OFFSET_O),
    .TERMINATION_IMPEDANCE_TEST_O(TERMINATION_IMPEDANCE_TEST_O),
    .ALPHA_COEFF_O(ALPHA_COEFF_O), .BETA_COEFF_O(BETA_COEFF_O),
    .CMD_ADDR_WORD_O(CMD_ADDR_WORD_O), .CMD_DATA_WORD_O(CMD_DATA_WORD_O));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One serial frame; phases of 6 cycles clear the 4-cycle minimum and sync delay
  task automatic frame(input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [31:0] w;
    w = {a, d};
    @(posedge CLK_I) UPCS_N_I <= 1'b0;
    cyc(4);
    for (int i = 31; i >= 0; i--) begin
      UPCK_I <= 1'b0;
      UPDI_I <= w[i];
      cyc(6);
      if (i < 16)
        r[i] = UPDO_O;
      UPCK_I <= 1'b1;
      cyc(6);
    end
    UPCK_I <= 1'b0;
    cyc(6);
    UPCS_N_I <= 1'b1;
    cyc(8);
  endtask

  // Unmapped places keep nothing and read zero
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    frame({1'b0, a}, d, q);
    if (msk.exists(a))
      model[a] = int'(d) & msk[a];
  endtask

  task automatic rd_chk(input logic [14:0] a);
    frame({1'b1, a}, 16'h0000, q);
    chk(q, model.exists(a) ? 16'(model[a]) : 16'h0000);
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    msk[15'h1ffc] = 'h1ff;
    msk[15'h1ffa] = 'h01f;
    msk[15'h1ff8] = 'h3ff;
    msk[15'h1ff6] = 'h0ff;
    model[15'h1ffc] = 'h1a3;
    model[15'h1ffa] = 0;
    model[15'h1ff8] = 'h0a4;
    model[15'h1ff6] = 0;
    cyc(5);
    RST_I <= 1'b0;
    cyc(3);
    // Reset values, command location and program store read back
    foreach (addrs[k])
      rd_chk(addrs[k]);
    // Random words across all 16 bits, unused bits included, then read back
    foreach (addrs[k]) begin
      wr(addrs[k], 16'(rnd()));
      rd_chk(addrs[k]);
    end
    chk(16'(SLOT_BIT_OFFSET_O), 16'(model[15'h1ffc]));
    chk(16'(TERMINATION_IMPEDANCE_TEST_O), 16'(model[15'h1ffa]));
    chk(16'(ALPHA_COEFF_O), 16'(model[15'h1ff8]));
    chk(16'(BETA_COEFF_O), 16'(model[15'h1ff6]));
    // Only the all-ones key clears the command words
    wr(15'h7fff, 16'h1234);
    chk({1'b0, CMD_ADDR_WORD_O}, 16'h7fff);
    chk(CMD_DATA_WORD_O, 16'h1234);
    wr(15'h7fff, 16'hffff);
    chk({1'b0, CMD_ADDR_WORD_O}, 16'h0000);
    chk(CMD_DATA_WORD_O, 16'h0000);
    // Fresh reset so transmission starts idle, then program the offset
    RST_I <= 1'b1;
    cyc(5);
    RST_I <= 1'b0;
    cyc(3);
    wr(15'h1ffa, 16'h0000);
    wr(15'h1ffc, 16'h0003);
    // Two frames of bit clocks; offset and slots repeat in each
    for (int fr = 0; fr < 2; fr++) begin
      FRAME_SYNC_STROBE_I <= 1'b1;
      cyc(4);
      FRAME_SYNC_STROBE_I <= 1'b0;
      cyc(4);
      for (int n = 0; n < 20; n++) begin
        SCK_I <= 1'b1;
        cyc(4);
        SCK_I <= 1'b0;
        cyc(4);
        if (n >= 3 && (n - 3) % 8 == 0)
          exp_slot++;
        chk(16'(TX_BIT_POS_O), 16'((n - 3) & 'h1ff));
        chk(16'(TX_ACTIVE_O), 16'(fr > 0 || n >= 3));
        chk(16'(n_slot), 16'(exp_slot));
      end
    end
    wrap_up();
  end
endmodule

bind board_control_registers board_ctrl_sva u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .UPCS_N_I(UPCS_N_I), .UPDO_OE_N_O(UPDO_OE_N_O),
  .SCK_I(SCK_I), .TX_BIT_POS_O(TX_BIT_POS_O), .TX_SLOT_START_O(TX_SLOT_START_O),
  .TX_ACTIVE_O(TX_ACTIVE_O), .SLOT_BIT_OFFSET_O(SLOT_BIT_OFFSET_O),
  .TERMINATION_IMPEDANCE_TEST_O(TERMINATION_IMPEDANCE_TEST_O),
  .ALPHA_COEFF_O(ALPHA_COEFF_O), .BETA_COEFF_O(BETA_COEFF_O),
  .CMD_ADDR_WORD_O(CMD_ADDR_WORD_O), .CMD_DATA_WORD_O(CMD_DATA_WORD_O));
